// ### sim/acrt_core_bench.sv
`timescale 1ns/1ps
module acrt_core_bench;
  import acrt_pkg::*;
  logic        i_ref_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic [15:0] i_sample = 16'h0;
  logic        i_convert_start, i_serial_clk, i_serial_chain_in;
  logic        o_serial_result_out, o_serial_result_oe, o_chain_mode, o_result_ready;
  logic [31:0] seen;
  int          mismatches = 0;
  int          total_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  acrt_core #(.VARIANT(VAR_FAST_C)) acrt_core_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_convert_start(i_convert_start), .i_serial_clk(i_serial_clk),
    .i_serial_chain_in(i_serial_chain_in), .i_sample(i_sample),
    .o_serial_result_out(o_serial_result_out), .o_serial_result_oe(o_serial_result_oe),
    .o_chain_mode(o_chain_mode), .o_result_ready(o_result_ready));
  acrt_host acrt_host_i (.i_ref_clk(i_ref_clk), .i_serial_result_out(o_serial_result_out),
    .o_convert_start(i_convert_start), .o_serial_clk(i_serial_clk),
    .o_serial_chain_in(i_serial_chain_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic test_cs;
    @(posedge i_ref_clk) i_sample <= 16'ha5c3;
    acrt_host_i.start(1'h0);
    check(o_result_ready, 1'h1);
    acrt_host_i.shift(1'h0, 16, 32'h0, seen);
    check(seen, 32'ha5c3);
    repeat (4) @(posedge i_ref_clk);
    check({o_chain_mode, o_serial_result_oe}, 2'h0);
    $display("test_cs done");
  endtask
  task automatic test_cs_release;
    @(posedge i_ref_clk) i_sample <= 16'h5a3c;
    acrt_host_i.start(1'h0);
    acrt_host_i.shift(1'h1, 4, 32'h0, seen);
    check(seen, 32'h5);
    check(o_serial_result_oe, 1'h1);
    acrt_host_i.deselect;
    repeat (4) @(posedge i_ref_clk);
    check({o_chain_mode, o_serial_result_oe}, 2'h0);
    $display("test_cs_release done");
  endtask
  task automatic test_chain;
    @(posedge i_ref_clk) i_sample <= 16'h3c96;
    acrt_host_i.start(1'h1);
    acrt_host_i.shift(1'h1, 32, 32'hb14e0000, seen);
    check(seen, 32'h3c96b14e);
    check(o_chain_mode, 1'h1);
    $display("test_chain done");
  endtask
  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    test_cs;
    test_cs_release;
    test_chain;
    print_verdict;
  end
  initial
  begin
    #200000;
    mismatches++;
    print_verdict;
  end
endmodule

// ### sim/acrt_host.sv
`timescale 1ns/1ps
module acrt_host (
  input  logic i_ref_clk,
  input  logic i_serial_result_out,
  output logic o_convert_start = 1'h0,
  output logic o_serial_clk = 1'h0,
  output logic o_serial_chain_in = 1'h1
);
  task automatic start(input logic chain);
    @(posedge i_ref_clk);
    o_serial_chain_in <= ~chain;
    o_convert_start <= 1'h0;
    repeat (4) @(posedge i_ref_clk);
    o_convert_start <= 1'h1;
    // Wait plus readout keeps rises over 2 us apart
    repeat (130) @(posedge i_ref_clk);
  endtask
  // One bit per 16 reference clocks; chain input moves just after each fall
  task automatic shift(input logic chain, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    dout = 32'h0;
    @(posedge i_ref_clk);
    o_convert_start <= chain;
    repeat (5) @(posedge i_ref_clk);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_ref_clk);
      o_serial_chain_in <= din[31-i];
      repeat (7) @(posedge i_ref_clk);
      o_serial_clk <= 1'h1;
      repeat (7) @(posedge i_ref_clk);
      dout = {dout[30:0], i_serial_result_out};
      @(posedge i_ref_clk);
      o_serial_clk <= 1'h0;
    end
  endtask
  task automatic deselect;
    @(posedge i_ref_clk);
    o_serial_chain_in <= 1'h1;
  endtask
endmodule

// ### sim/acrt_monitor.sv
`timescale 1ns/1ps
module acrt_monitor (
  input logic i_ref_clk,
  input logic i_rst,
  input logic i_convert_start,
  input logic i_serial_clk,
  input logic i_serial_chain_in,
  input logic o_serial_result_out,
  input logic o_serial_result_oe,
  input logic o_chain_mode,
  input logic o_result_ready
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_ready_in_time: assert property ($rose(i_convert_start) |-> ##[1:6] !o_result_ready
    ##[100:130] o_result_ready) else $error("ready late");
  a_drive_ready: assert property ($rose(o_serial_result_oe) |-> o_result_ready)
    else $error("drive early");
  a_cs_release: assert property ((!o_chain_mode && i_convert_start && i_serial_chain_in)[*6]
    |-> !o_serial_result_oe) else $error("no release");
  a_bit_steady: assert property ((o_serial_result_oe && i_serial_clk)[*6] |=>
    $stable(o_serial_result_out) || !o_serial_result_oe) else $error("bit moved");
  a_chain_drive: assert property ((o_chain_mode && o_result_ready)[*3]
    |-> o_serial_result_oe) else $error("chain idle");
  a_mode_hold: assert property (o_result_ready && $past(o_result_ready)
    |-> $stable(o_chain_mode)) else $error("mode moved");
endmodule
bind acrt_core acrt_monitor acrt_monitor_i (.*);

// ### verilog/acrt_core.sv
`timescale 1ns/1ps
module acrt_core
  import acrt_pkg::*;
#(
  parameter logic [1:0] VARIANT = acrt_pkg::VAR_SLOW,
  parameter int unsigned BITS = acrt_pkg::RESULT_BITS
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_convert_start,
  input  wire logic                          i_serial_clk,
  input  wire logic                          i_serial_chain_in,
  input  wire logic [acrt_pkg::RESULT_BITS-1:0] i_sample,
  output logic                               o_serial_result_out,
  output logic                               o_serial_result_oe,
  output logic                               o_chain_mode,
  output logic                               o_result_ready
);
  import acrt_pkg::*;

  localparam int unsigned CONV_CYC = (VARIANT == VAR_FAST_B) ? CONV_FAST_B_CYC :
                                     (VARIANT == VAR_FAST_C) ? CONV_FAST_C_CYC :
                                     CONV_SLOW_CYC;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [4:0] BITS_LAST = 5'(BITS);

  typedef struct packed {
    acrt_state_t       state;
    logic [CNT_W-1:0]  cnt;
    logic              convert_start;
    logic              sck;
    logic              mode_chain;
    logic [BITS-1:0]   shreg;
    logic [4:0]        sent;
    logic              oe;
    logic              dout;
  } acrt_core_t;

  acrt_core_t r_q;
  acrt_core_t r_d;
  logic [2:0] pins_s;
  logic       cnv_s;
  logic       sck_s;
  logic       sdi_s;
  logic       cnv_rise;
  logic       sck_fall;
  logic       selected;

  acrt_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_convert_start, i_serial_clk, i_serial_chain_in}),
    .o_sync    (pins_s)
  );

  assign cnv_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];
  assign cnv_rise = cnv_s & ~r_q.convert_start;
  assign sck_fall = ~sck_s & r_q.sck;
  // Either select low enables the output in chip-select mode
  assign selected = ~cnv_s | ~sdi_s;

  always_comb
  begin
    r_d = r_q;
    r_d.convert_start = cnv_s;
    r_d.sck = sck_s;
    unique case (r_q.state)
      ACRT_IDLE:
      begin
        r_d.oe = 1'b0;
      end
      ACRT_CONV:
      begin
        r_d.cnt = r_q.cnt + CNT_W'(1);
        if (r_q.cnt == CONV_LAST) // see [R1]
        begin
          r_d.state = ACRT_DONE;
          r_d.shreg = i_sample;
          r_d.dout = i_sample[BITS-1];
          r_d.sent = '0;
        end
      end
      ACRT_DONE:
      begin
        if (r_q.mode_chain)
        begin
          // Output driven whenever result is held; host reads while convert_start high
          r_d.oe = 1'b1;
          if (sck_fall) // see [R9]
          begin
            r_d.shreg = {r_q.shreg[BITS-2:0], sdi_s}; // see [R11]
            r_d.dout = r_q.shreg[BITS-2]; // see [R6]
          end
        end
        else if (!selected || r_q.sent == BITS_LAST)
        begin
          r_d.oe = 1'b0; // see [R5]
        end
        else
        begin
          r_d.oe = 1'b1; // see [R4]
          if (sck_fall)
          begin
            r_d.shreg = {r_q.shreg[BITS-2:0], 1'b0};
            r_d.dout = r_q.shreg[BITS-2]; // see [R6]
            r_d.sent = r_q.sent + 5'h1;
            if (r_q.sent == BITS_LAST - 5'h1)
            begin
              r_d.oe = 1'b0; // see [R5]
            end
          end
        end
      end
      default:
      begin
        r_d.state = ACRT_IDLE;
      end
    endcase
    // A new conversion aborts any readout in progress
    if (cnv_rise)
    begin
      r_d.state = ACRT_CONV;
      r_d.cnt = '0;
      r_d.oe = 1'b0;
      r_d.mode_chain = ~sdi_s; // see [R10]
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_q <= '{state: ACRT_IDLE, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_serial_result_out = r_q.dout;
  assign o_serial_result_oe = r_q.oe;
  assign o_chain_mode = r_q.mode_chain;
  assign o_result_ready = (r_q.state == ACRT_DONE);
endmodule

// ### verilog/acrt_pkg.sv
// Function
// [R1] Result is ready within the variant conversion time after convert_start rises; code is 2 to 3 reference clocks later (input sync).
// [R2] Host holds convert_start high at least 500 ns in chip-select mode.
// [R3] Host keeps serial clock period at least 22 ns or 23 ns by mode.
// [R4] Chip-select mode drives result_top_bit first once convert_start or chain input low.
// [R5] Chip-select mode releases output when either select returns high or after last bit; code releases after last bit or once both selects are high.
// [R6] Output advances one bit per serial clock falling edge; host captures before next.
// [R7] Host sets serial_chain_in level before each convert_start rising edge.
// [R8] Host keeps serial clock stable around convert_start rising edge in daisy-chain mode.
// [R9] Daisy-chain mode captures serial_chain_in on serial clock falling edges.
// [R10] Chain input low at convert_start rise selects daisy-chain, high selects chip-select.
// [R11] Daisy-chain mode reproduces chain input on output after exactly 16 clock cycles.
// [R12] Host reads out in daisy-chain mode while convert_start stays high.
// [R13] Host spaces convert_start rises by the variant minimum cycle time.
package acrt_pkg;
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned CLK_FREQ_MHZ = 100;
  // Conversion times in nanoseconds, per variant
  localparam int unsigned T_CONV_SLOW_NS = 9500;
  localparam int unsigned T_CONV_FAST_B_NS = 1600;
  localparam int unsigned T_CONV_FAST_C_NS = 1200;
  localparam int unsigned T_CNVH_NS = 500;
  // Each time rounds down
  localparam int unsigned CONV_SLOW_CYC = T_CONV_SLOW_NS * CLK_FREQ_MHZ / 1000;
  localparam int unsigned CONV_FAST_B_CYC = T_CONV_FAST_B_NS * CLK_FREQ_MHZ / 1000;
  localparam int unsigned CONV_FAST_C_CYC = T_CONV_FAST_C_NS * CLK_FREQ_MHZ / 1000;
  localparam int unsigned CNT_W = 12;
  localparam logic [1:0] VAR_SLOW = 2'h0;
  localparam logic [1:0] VAR_FAST_B = 2'h1;
  localparam logic [1:0] VAR_FAST_C = 2'h2;
  typedef enum logic [2:0] {
    ACRT_IDLE = 3'b001,
    ACRT_CONV = 3'b010,
    ACRT_DONE = 3'b100
  } acrt_state_t;
endpackage

// ### verilog/acrt_sync.sv
`timescale 1ns/1ps
module acrt_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acrt_sync_t;

  acrt_sync_t s_q;
  acrt_sync_t s_d;

  always_comb
  begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;
endmodule
